//--- hdl/gtp_map.svh
/*
 * register offsets, field positions, reset values and service vector of the gated
 * timer event block. assumes a 32-bit avalon-mm slave, one word per register.
 */
`ifndef GTP_MAP_SVH
`define GTP_MAP_SVH

// register byte addresses (word aligned)
`define GTP_OFS_TIMER_CONTROL  5'h00
`define GTP_OFS_GATE_CONTROL   5'h04
`define GTP_OFS_COUNT_LOW      5'h08
`define GTP_OFS_COUNT_HIGH     5'h0c
`define GTP_ADDR_W             5

// timer_control fields
`define GTP_TC_ON              0
`define GTP_TC_ASYNC           2
`define GTP_TC_PS_LO           4
`define GTP_TC_CS_LO           6
`define GTP_TC_WMASK           8'hf5
`define GTP_TC_RESET           8'h00

// gate_control fields
`define GTP_GC_SRC_LO          0
`define GTP_GC_LEVEL           2
`define GTP_GC_GO              3
`define GTP_GC_SPM             4
`define GTP_GC_TOGGLE          5
`define GTP_GC_POL             6
`define GTP_GC_ENABLE          7
`define GTP_GC_RESET           8'h00

// peripheral flag/enable register (word at 0x10): overflow and gate flags and their enables
`define GTP_OFS_FLAGS          5'h10
`define GTP_FL_OVF             0
`define GTP_FL_GATE            1
`define GTP_FL_OVF_IE          8
`define GTP_FL_GATE_IE         9

// interrupt service entry address
`define GTP_ISR_VECTOR         16'h0004

`endif

//--- hdl/gtp_pkg.sv
/*
 * types shared by the gated timer event block.
 * assumes gtp_map.svh is included by its users for the numbers.
 */
package gtp_pkg;
	typedef enum logic [1:0] {GTP_CS_FOSC4, GTP_CS_FOSC, GTP_CS_PIN, GTP_CS_TEMP} gtp_clk_src_t;
	typedef enum logic [1:0] {GTP_PS_1, GTP_PS_2, GTP_PS_4, GTP_PS_8} gtp_prescale_t;
	typedef enum logic [1:0] {GTP_SP_IDLE, GTP_SP_ARMED, GTP_SP_RUN} gtp_sp_state_t;
endpackage : gtp_pkg

//--- hdl/gtp_timer.sv
/*
 * gated 16-bit timer/counter with single-pulse gate capture, gate event and
 * rollover flags, sleep wake, capture/compare time base and special event clear.
 * assumes pins arrive asynchronous to core_clk, software on avalon-mm with
 * waitrequest; gate source selection beyond the gate pin is done outside.
 */
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "gtp_map.svh"

// Overview of operation
// - go set: count from next gate edge
// - go cleared at gate pulse trailing edge
// - after pulse, gate blocked until go again
// - clearing pulse enable also clears go
// - toggle plus pulse measures full gate cycle
// - gate level readable, even gate disabled
// - gate level falling edge sets gate flag
// - gate irq when flag and enable set
// - gate flag works with gate disabled
// - counter wraps ffff to 0000, sets overflow
// - overflow flag sticky until software clears
// - sleep counts only async external, overflow wakes
// - after wake vector to 0004 if global
// - capture copies counter on configured event
// - compare event when compare equals counter
// - special trigger clears counter, no overflow flag
// - software counter write beats special trigger
// - prescale field divides by 1,2,4,8
// - source: temp osc, pin, fosc, fosc/4
// - async bit skips second pin synchroniser stage
// - off unless on; gate enable gates counting
module gtp_timer
	import gtp_pkg::*;
(
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         sys_rst,
	// avalon-mm slave
	input  wire logic [4:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	input  wire logic [3:0]   avs_byteenable,
	output logic [31:0]       avs_readdata,
	output logic              avs_waitrequest,
	// pins and sources
	input  wire logic         external_count_pin,
	input  wire logic         gate_input,
	input  wire logic         temp_osc,
	// system context
	input  wire logic         sleep_mode,
	input  wire logic         peripheral_irq_enable,
	input  wire logic         global_irq_enable,
	// capture/compare unit
	input  wire logic         capture_event,
	input  wire logic         special_trigger,
	input  wire logic [7:0]   compare_low_byte,
	input  wire logic [7:0]   compare_high_byte,
	// results
	output logic [15:0]       capture_value,
	output logic              compare_match,
	output logic              gate_irq,
	output logic              overflow_irq,
	output logic              wake_request,
	output logic              vector_request,
	output logic [15:0]       vector_address
);
	import gtp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: first stage read by second stage and by the async count pin path
	logic [2:0] syncA;
	logic [2:0] syncB;
	logic [2:0] pinSync;
	logic [2:0] pinPrev;
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			syncA   <= 3'h0;
			syncB   <= 3'h0;
			pinPrev <= 3'h0;
		end
		else
		begin
			syncA   <= {temp_osc, gate_input, external_count_pin};
			syncB   <= syncA;
			pinPrev <= syncB;
		end
	end
	assign pinSync = syncB;

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]  timerControl;
	logic [7:0]  gateControl;
	logic [15:0] count;
	logic [2:0]  prescaleCount;
	logic        toggleFf;
	logic        gateLevel;
	logic        gateEventFlag;
	logic        overflowFlag;
	logic        gateIrqEnable;
	logic        overflowIrqEnable;
	gtp_sp_state_t spState;

	wire gtp_clk_src_t  clkSrc   = gtp_clk_src_t'(timerControl[`GTP_TC_CS_LO +: 2]);
	wire gtp_prescale_t psSel    = gtp_prescale_t'(timerControl[`GTP_TC_PS_LO +: 2]);
	wire timerOn   = timerControl[`GTP_TC_ON];
	wire asyncSel  = timerControl[`GTP_TC_ASYNC];
	wire gateEn    = gateControl[`GTP_GC_ENABLE];
	wire gatePol   = gateControl[`GTP_GC_POL];
	wire toggleEn  = gateControl[`GTP_GC_TOGGLE];
	wire spmEn     = gateControl[`GTP_GC_SPM];
	wire goBit     = gateControl[`GTP_GC_GO];

	////////////////////////////////////////////////////////////////////////////
	// bus decode: every access answered one cycle after request
	logic busAck;
	wire busReq   = (avs_read || avs_write) && !busAck;
	// a write lands only at the edge where waitrequest is seen low
	wire wrStrobe = avs_write && busAck && avs_byteenable[0];
	wire selTc    = avs_address == 5'(`GTP_OFS_TIMER_CONTROL);
	wire selGc    = avs_address == 5'(`GTP_OFS_GATE_CONTROL);
	wire selLo    = avs_address == 5'(`GTP_OFS_COUNT_LOW);
	wire selHi    = avs_address == 5'(`GTP_OFS_COUNT_HIGH);
	wire selFl    = avs_address == 5'(`GTP_OFS_FLAGS);
	wire wrTc     = wrStrobe && selTc;
	wire wrGc     = wrStrobe && selGc;
	wire wrLo     = wrStrobe && selLo;
	wire wrHi     = wrStrobe && selHi;
	wire wrFl     = wrStrobe && selFl;
	wire [7:0] wd = avs_writedata[7:0];
	wire [31:0] rdMux =
		selTc ? {24'h0, timerControl} :
		selGc ? {24'h0, gateControl[7:3], gateLevel, gateControl[1:0]} :
		selLo ? {24'h0, count[7:0]} :
		selHi ? {24'h0, count[15:8]} :
		selFl ? {22'h0, gateIrqEnable, overflowIrqEnable, 6'h0, gateEventFlag,
			overflowFlag} :
		32'h0;

	////////////////////////////////////////////////////////////////////////////
	// clock selection and prescale
	logic fosc4Tick;
	logic [1:0] fosc4Div;
	wire pinRise   = pinSync[0] && !pinPrev[0];
	wire rawPin    = syncA[0];
	logic rawPinPrev;
	// async mode trades one stage of metastability margin for sleep counting
	wire pinEdge   = asyncSel ? (rawPin && !rawPinPrev) : pinRise;
	wire tempRise  = pinSync[2] && !pinPrev[2];
	wire srcTick   =
		(clkSrc == GTP_CS_TEMP)  ? tempRise :
		(clkSrc == GTP_CS_PIN)   ? pinEdge :
		(clkSrc == GTP_CS_FOSC)  ? 1'b1 :
		fosc4Tick;
	wire [2:0] psMask =
		(psSel == GTP_PS_8) ? 3'h7 :
		(psSel == GTP_PS_4) ? 3'h3 :
		(psSel == GTP_PS_2) ? 3'h1 : 3'h0;
	wire asyncExt  = asyncSel && (clkSrc == GTP_CS_PIN);
	wire sleepOk   = !sleep_mode || asyncExt;
	wire psTick    = srcTick && ((prescaleCount & psMask) == psMask);

	////////////////////////////////////////////////////////////////////////////
	// gate path
	wire gateRaw     = pinSync[1] ~^ gatePol;
	wire gateRawPrev = pinPrev[1] ~^ gatePol;
	wire gateInc     = gateRaw && !gateRawPrev;
	wire toggled     = toggleEn ? toggleFf : gateRaw;
	// in toggle mode the measured window opens when the flip-flop goes high
	wire toggledRise = toggleEn ? (gateInc && !toggleFf) : gateInc;
	wire next_gateLevel = spmEn ? (toggled && spState == GTP_SP_RUN) : toggled;
	wire gateFall    = gateLevel && !next_gateLevel;
	wire countEn     = timerOn && (!gateEn || gateLevel) && sleepOk;
	wire incr        = countEn && psTick;
	wire wrap        = incr && count == 16'hffff;
	wire cntWrite    = wrLo || wrHi;
	wire spDone      = spState == GTP_SP_RUN && gateFall;

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fosc4Div   <= 2'h0;
			fosc4Tick  <= 1'b0;
			rawPinPrev <= 1'b0;
			toggleFf   <= 1'b0;
			gateLevel  <= 1'b0;
		end
		else
		begin
			fosc4Div   <= fosc4Div + 2'h1;
			fosc4Tick  <= fosc4Div == 2'h3;
			rawPinPrev <= rawPin;
			if (!toggleEn || !timerOn)
				toggleFf <= 1'b0;
			else if (gateInc)
				toggleFf <= !toggleFf;
			gateLevel  <= next_gateLevel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// single-pulse sequencer
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			spState <= GTP_SP_IDLE;
		else if (!spmEn || !goBit || spDone)
			spState <= GTP_SP_IDLE;
		else
			case (spState)
				GTP_SP_IDLE:  spState <= GTP_SP_ARMED;
				GTP_SP_ARMED: if (toggledRise)
					spState <= GTP_SP_RUN;
				default:      spState <= GTP_SP_RUN;
			endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers and flags
	wire [7:0] next_gc = {wd[7:4], wd[3] && wd[4], 1'b0, wd[1:0]};
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			timerControl      <= `GTP_TC_RESET;
			gateControl       <= `GTP_GC_RESET;
			gateEventFlag     <= 1'b0;
			overflowFlag      <= 1'b0;
			gateIrqEnable     <= 1'b0;
			overflowIrqEnable <= 1'b0;
		end
		else
		begin
			if (wrTc)
				timerControl <= wd & `GTP_TC_WMASK;
			if (wrGc)
				gateControl <= next_gc;
			else if (spDone)
				gateControl[`GTP_GC_GO] <= 1'b0;
			if (wrFl)
			begin
				gateIrqEnable     <= avs_writedata[`GTP_FL_GATE_IE];
				overflowIrqEnable <= avs_writedata[`GTP_FL_OVF_IE];
			end
			// write one to clear; a new event in the same cycle wins
			if (gateFall)
				gateEventFlag <= 1'b1;
			else if (wrFl && avs_writedata[`GTP_FL_GATE])
				gateEventFlag <= 1'b0;
			if (wrap)
				overflowFlag <= 1'b1;
			else if (wrFl && avs_writedata[`GTP_FL_OVF])
				overflowFlag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// counter, prescaler, capture/compare
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			count         <= 16'h0000;
			prescaleCount <= 3'h0;
			capture_value <= 16'h0000;
			compare_match <= 1'b0;
		end
		else
		begin
			if (cntWrite)
				prescaleCount <= 3'h0;
			else if (countEn && srcTick)
				prescaleCount <= prescaleCount + 3'h1;
			if (wrLo)
				count[7:0] <= wd;
			else if (wrHi)
				count[15:8] <= wd;
			else if (special_trigger)
				count <= 16'h0000;
			else if (incr)
				count <= count + 16'h0001;
			if (capture_event)
				capture_value <= count;
			compare_match <= count == {compare_high_byte, compare_low_byte};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt, wake and bus answer outputs
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			busAck          <= 1'b0;
			avs_readdata    <= 32'h0;
			gate_irq        <= 1'b0;
			overflow_irq    <= 1'b0;
			wake_request    <= 1'b0;
			vector_request  <= 1'b0;
			vector_address  <= 16'h0000;
		end
		else
		begin
			busAck       <= busReq;
			if (busReq && avs_read)
				avs_readdata <= rdMux;
			gate_irq     <= gateEventFlag && gateIrqEnable;
			overflow_irq <= overflowFlag && overflowIrqEnable;
			wake_request <= sleep_mode && overflowFlag && overflowIrqEnable
				&& peripheral_irq_enable;
			vector_request <= (overflowFlag && overflowIrqEnable || gateEventFlag
				&& gateIrqEnable) && peripheral_irq_enable && global_irq_enable;
			vector_address <= `GTP_ISR_VECTOR;
		end
	end
	assign avs_waitrequest = !busAck;

endmodule // gtp_timer
`default_nettype wire

//--- dv/gtp_timer_sva.sv
/* port checker for gtp_timer.
   assumes bind from the bench top; one clock, async reset */
`timescale 1ns/1ps
`default_nettype none
module gtp_timer_chk (
	// clock and bus
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire logic [4:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// context and results
	input wire logic        global_irq_enable,
	input wire logic        sleep_mode,
	input wire logic        wake_request,
	input wire logic        vector_request,
	input wire logic [15:0] vector_address
);
default clocking @(posedge core_clk); endclocking
default disable iff (sys_rst);
logic [7:0] tcShadow;
logic [7:0] gcShadow;
wire ack = !avs_waitrequest && (avs_read || avs_write);
wire wrAck = ack && avs_write && avs_byteenable[0];
wire rdAck = ack && avs_read;
always_ff @(posedge core_clk or posedge sys_rst)
	if (sys_rst)
		tcShadow <= 8'h00;
	else if (wrAck && avs_address == 5'h00)
		tcShadow <= avs_writedata[7:0];
always_ff @(posedge core_clk or posedge sys_rst)
	if (sys_rst)
		gcShadow <= 8'h00;
	else if (wrAck && avs_address == 5'h04)
		gcShadow <= avs_writedata[7:0];
////////////////////////////////////////////////////////////////
sequence s_req;
	(avs_read || avs_write) && avs_waitrequest;
endsequence
property p_answer; s_req |=> !avs_waitrequest; endproperty
property p_once; !avs_waitrequest |=> avs_waitrequest; endproperty
property p_tc; rdAck && avs_address == 5'h00 |-> avs_readdata[7:0] == (tcShadow & 8'hf5);
endproperty
property p_gc; rdAck && avs_address == 5'h04
	|-> {avs_readdata[7:4], avs_readdata[1:0]} == {gcShadow[7:4], gcShadow[1:0]}; endproperty
property p_spm; rdAck && avs_address == 5'h04 && !gcShadow[4] |-> !avs_readdata[3];
endproperty
property p_unmap; rdAck && avs_address > 5'h10 |-> avs_readdata == 32'h0; endproperty
property p_vec; vector_request |-> vector_address == 16'h0004; endproperty
property p_gie; $rose(vector_request) |-> $past(global_irq_enable); endproperty
property p_wake; $rose(wake_request) |-> $past(sleep_mode); endproperty
a_answer: assert property (p_answer) else $error("no answer one cycle after request");
a_once: assert property (p_once) else $error("waitrequest low too long");
a_tc: assert property (p_tc) else $error("timer control readback wrong");
a_gc: assert property (p_gc) else $error("gate control readback wrong");
a_spm: assert property (p_spm) else $error("go set with pulse mode off");
a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
a_vec: assert property (p_vec) else $error("wrong service entry");
a_gie: assert property (p_gie) else $error("vector without global enable");
a_wake: assert property (p_wake) else $error("wake outside sleep");
endmodule // gtp_timer_chk
`default_nettype wire

//--- dv/gtp_pin_model.sv
/* gate pin and external count pin source.
   assumes the bench calls its tasks; pins never float */
`timescale 1ns/1ps
`default_nettype none
module gtp_pin_model (
	// clock
	input wire logic core_clk,
	// pins
	output logic     gateInput,
	output logic     countPin
);
initial
begin
	gateInput = 1'b0;
	countPin = 1'b0;
end
// levels held 4 cycles so the two-flop synchroniser sees them
task automatic level(input logic v);
	@(posedge core_clk);
	gateInput <= v;
	repeat (4) @(posedge core_clk);
endtask
task automatic ticks(input int n);
	repeat (n)
	begin
		@(posedge core_clk);
		countPin <= 1'b1;
		repeat (3) @(posedge core_clk);
		countPin <= 1'b0;
		repeat (3) @(posedge core_clk);
	end
endtask
endmodule // gtp_pin_model
`default_nettype wire

//--- dv/gated_timer_pulse_events_test.sv
/* self-checking bench for gtp_timer.
   assumes checker and pin model compiled first */
`timescale 1ns/1ps
`default_nettype none
module gated_timer_pulse_events_test;
logic coreClk, sysRst, avsRead, avsWrite, sleepMode, periphIe, globalIe, capEvt, specTrig;
logic tempOsc;
logic [3:0] avsBe;
logic [7:0] cmpLo, cmpHi;
logic [4:0] avsAddress;
logic [31:0] avsWritedata, rv;
logic [7:0] cnt;
wire [31:0] avsReaddata;
wire [15:0] capVal, vecAddr;
wire avsWait, gateIn, cntPin, cmpMatch, gateIrq, ovfIrq, wakeReq, vecReq;
int errorCnt, nTests, cyc;
gtp_pin_model pm (.core_clk(coreClk), .gateInput(gateIn), .countPin(cntPin));
gtp_timer DUT (.core_clk(coreClk), .sys_rst(sysRst), .avs_address(avsAddress),
	.avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
	.avs_byteenable(avsBe), .avs_readdata(avsReaddata), .avs_waitrequest(avsWait),
	.external_count_pin(cntPin), .gate_input(gateIn), .temp_osc(tempOsc),
	.sleep_mode(sleepMode), .peripheral_irq_enable(periphIe),
	.global_irq_enable(globalIe), .capture_event(capEvt), .special_trigger(specTrig),
	.compare_low_byte(cmpLo), .compare_high_byte(cmpHi), .capture_value(capVal),
	.compare_match(cmpMatch), .gate_irq(gateIrq), .overflow_irq(ovfIrq),
	.wake_request(wakeReq), .vector_request(vecReq), .vector_address(vecAddr));
initial
begin
	coreClk = 1'b0;
	forever #12.5 coreClk = ~coreClk;
end
task automatic conclude;
	if (errorCnt == 0 && nTests > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
always @(posedge coreClk)
begin
	cyc++;
	if (cyc == 20000)
	begin
		errorCnt++;
		conclude();
	end
end
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	nTests++;
	if (got !== exp)
	begin
		errorCnt++;
		$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask
task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
	@(posedge coreClk);
	avsAddress <= a;
	avsWrite <= w;
	avsRead <= !w;
	avsWritedata <= d;
	@(posedge coreClk);
	while (avsWait) @(posedge coreClk);
	rv = avsReaddata;
	avsWrite <= 1'b0;
	avsRead <= 1'b0;
endtask
task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
	bus(1'b0, a, 32'h0);
	chk(rv & m, e);
endtask
task automatic pulse(input bit which);
	@(posedge coreClk);
	if (which)
		capEvt <= 1'b1;
	else
		specTrig <= 1'b1;
	@(posedge coreClk);
	capEvt <= 1'b0;
	specTrig <= 1'b0;
	repeat (3) @(posedge coreClk);
endtask
initial
begin
	{sysRst, avsRead, avsWrite, capEvt, specTrig, sleepMode} = 6'h20;
	{periphIe, globalIe} = 2'h3;
	avsAddress = 5'h00;
	avsWritedata = 32'h0;
	tempOsc = 1'b0;
	avsBe = 4'hf;
	cmpLo = 8'h34;
	cmpHi = 8'h12;
	repeat (16) @(posedge coreClk);
	sysRst <= 1'b0;
	rdc(5'h04, 32'hfb, 32'h0);
	rdc(5'h10, 32'h303, 32'h0);
	bus(1'b1, 5'h00, 32'hff);
	rdc(5'h00, 32'hff, 32'hf5);
	avsBe <= 4'h0;
	bus(1'b1, 5'h00, 32'h00);
	avsBe <= 4'hf;
	rdc(5'h00, 32'hff, 32'hf5);
	rdc(5'h14, 32'hffffffff, 32'h0);
	bus(1'b1, 5'h00, 32'h40);
	bus(1'b1, 5'h0c, 32'hff);
	bus(1'b1, 5'h08, 32'hfd);
	bus(1'b1, 5'h10, 32'h100);
	bus(1'b1, 5'h00, 32'h41);
	repeat (8) @(posedge coreClk);
	bus(1'b1, 5'h00, 32'h40);
	rdc(5'h0c, 32'hff, 32'h0);
	chk(ovfIrq, 1'b1);
	repeat (4) @(posedge coreClk);
	rdc(5'h10, 32'h1, 32'h1);
	bus(1'b1, 5'h10, 32'h101);
	rdc(5'h10, 32'h1, 32'h0);
	bus(1'b1, 5'h08, 32'h55);
	pulse(1'b0);
	rdc(5'h08, 32'hff, 32'h0);
	rdc(5'h10, 32'h1, 32'h0);
	bus(1'b1, 5'h0c, 32'h12);
	bus(1'b1, 5'h08, 32'h34);
	pulse(1'b1);
	chk(capVal, 16'h1234);
	chk(cmpMatch, 1'b1);
	bus(1'b1, 5'h0c, 32'h0);
	for (int p = 0; p < 4; p++)
	begin
		bus(1'b1, 5'h08, 32'h0);
		bus(1'b1, 5'h00, {24'h0, 2'b10, p[1:0], 4'h1});
		pm.ticks(8);
		rdc(5'h08, 32'hff, 32'h8 >> p);
	end
	bus(1'b1, 5'h08, 32'h0);
	bus(1'b1, 5'h00, 32'hc1);
	repeat (3)
	begin
		tempOsc <= 1'b1;
		repeat (4) @(posedge coreClk);
		tempOsc <= 1'b0;
		repeat (4) @(posedge coreClk);
	end
	rdc(5'h08, 32'hff, 32'h3);
	bus(1'b1, 5'h10, 32'h200);
	bus(1'b1, 5'h04, 32'h40);
	pm.level(1'b1);
	rdc(5'h04, 32'h4, 32'h4);
	pm.level(1'b0);
	rdc(5'h10, 32'h2, 32'h2);
	chk(gateIrq, 1'b1);
	bus(1'b1, 5'h10, 32'h2);
	repeat (2) @(posedge coreClk);
	chk(gateIrq, 1'b0);
	bus(1'b1, 5'h08, 32'h0);
	bus(1'b1, 5'h00, 32'h41);
	bus(1'b1, 5'h04, 32'hd0);
	bus(1'b1, 5'h04, 32'hd8);
	pm.level(1'b1);
	repeat (20) @(posedge coreClk);
	pm.level(1'b0);
	rdc(5'h04, 32'h8, 32'h0);
	cnt = rv[7:0];
	bus(1'b0, 5'h08, 32'h0);
	cnt = rv[7:0];
	chk(cnt > 8'h0a && cnt < 8'h28, 1'b1);
	pm.level(1'b1);
	pm.level(1'b0);
	rdc(5'h08, 32'hff, {24'h0, cnt});
	bus(1'b1, 5'h04, 32'hd8);
	rdc(5'h04, 32'h8, 32'h8);
	bus(1'b1, 5'h04, 32'hc0);
	rdc(5'h04, 32'h8, 32'h0);
	bus(1'b1, 5'h04, 32'hf8);
	pm.level(1'b1);
	pm.level(1'b0);
	rdc(5'h04, 32'h8, 32'h8);
	pm.level(1'b1);
	pm.level(1'b0);
	rdc(5'h04, 32'h8, 32'h0);
	bus(1'b1, 5'h04, 32'h0);
	bus(1'b1, 5'h00, 32'h80);
	bus(1'b1, 5'h0c, 32'hff);
	bus(1'b1, 5'h08, 32'hff);
	bus(1'b1, 5'h10, 32'h100);
	bus(1'b1, 5'h00, 32'h85);
	sleepMode <= 1'b1;
	pm.ticks(2);
	chk(wakeReq, 1'b1);
	sleepMode <= 1'b0;
	repeat (4) @(posedge coreClk);
	chk(vecReq, 1'b1);
	chk(vecAddr, 16'h0004);
	conclude();
end
endmodule // gated_timer_pulse_events_test
bind gtp_timer gtp_timer_chk chk_i (.core_clk(core_clk), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.global_irq_enable(global_irq_enable), .sleep_mode(sleep_mode),
	.wake_request(wake_request), .vector_request(vector_request),
	.vector_address(vector_address));
`default_nettype wire
